// >>> rtl/read_chan_pkg.sv
// shared constants for the read channel pulse and sync logic
package read_chan_pkg;
   // clock rate
   localparam int CLK_MHZ        = 40;
   // digitized pulse width, least time, rounded up
   localparam int PULSE_NS       = 50;
   localparam int PULSE_CYC      = (PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int PULSE_CNT_W    = 2;
   // silence that marks a boundary
   localparam int GAP_MS         = 10;
   localparam int GAP_CYC        = GAP_MS * CLK_MHZ * 1000;
   localparam int GAP_CNT_W      = 20;
   // boundary strobe length
   localparam int STROBE_NS      = 2000;
   localparam int STROBE_CYC     = (STROBE_NS * CLK_MHZ + 999) / 1000;
   localparam int STROBE_CNT_W   = 7;
   // oscillator reset pulse length in cycles
   localparam int OSC_RESET_CYC  = 2;
   localparam int OSC_CNT_W      = 2;
   // synchroniser lanes
   localparam int SYNC_W         = 4;
   localparam int S_TRANS        = 0;
   localparam int S_GATE         = 1;
   localparam int S_MASTER       = 2;
   localparam int S_OSC          = 3;
endpackage

// >>> rtl/disk_read_pulse_sync_logic.sv
// read pulse shaping, boundary detection and phase detector of the read path
// Behaviour
// - one fixed 50 ns pulse per transition
// - about 10 ms without pulses means boundary
// - boundary gives one 2 us strobe
// - resumed pulses quickly re-arm boundary detector
// - front end always on; PLL gated
// - gate idle: lock to master clock
// - gate active: lock to read pulses
// - pulse before oscillator: speed-up request
// - oscillator before pulse: slow-down request
// - read mode supplies clock and NRZ data
// - oscillator halved to double and bit rate
// - gate rise resets detector, pulses oscillator reset
// - both registered: clear both requests
module disk_read_pulse_sync_logic
#(
   parameter int GAP_CYCLES = read_chan_pkg::GAP_CYC
) (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic nrst,
   // pins from analog front end and controller
   input  wire logic read_transition,
   input  wire logic read_gate_enable,
   input  wire logic master_bit_clock,
   input  wire logic quad_rate_oscillator_clock,
   // front end outputs
   output logic      digitized_read_pulse,
   output logic      boundary_strobe,
   // charge pump and oscillator control
   output logic      speed_up_request,
   output logic      slow_down_request,
   output logic      idle_speed_up_request,
   output logic      idle_slow_down_request,
   output logic      oscillator_reset_pulse,
   // derived clocks and decoded data
   output logic      double_rate_clock,
   output logic      bit_rate_clock,
   output logic      read_clock,
   output logic      nrz_read_data
);
   import read_chan_pkg::*;
   localparam logic [GAP_CNT_W-1:0] GAP_MAX = GAP_CNT_W'(GAP_CYCLES);
   ////////////////////////////////////////////////////////////////////////////
   // input synchronisers; stage one feeds only stage two
   logic [SYNC_W-1:0] sync1_reg;
   logic [SYNC_W-1:0] sync2_reg;
   logic [SYNC_W-1:0] sync3_reg;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         sync3_reg <= '0;
      end else begin
         sync1_reg <= {quad_rate_oscillator_clock, master_bit_clock,
                       read_gate_enable, read_transition};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end
   // both edges of the analog comparator count as transitions
   logic trans_evt;
   logic gate_s;
   logic gate_rise;
   logic gate_fall;
   logic master_rise;
   logic osc_rise;
   assign trans_evt   = sync2_reg[S_TRANS] ^ sync3_reg[S_TRANS];
   assign gate_s      = sync2_reg[S_GATE];
   assign gate_rise   = gate_s & ~sync3_reg[S_GATE];
   assign gate_fall   = ~gate_s & sync3_reg[S_GATE];
   assign master_rise = sync2_reg[S_MASTER] & ~sync3_reg[S_MASTER];
   assign osc_rise    = sync2_reg[S_OSC] & ~sync3_reg[S_OSC];
   ////////////////////////////////////////////////////////////////////////////
   // pulse shaper and boundary detector, never gated
   logic [PULSE_CNT_W-1:0]  pulse_cnt_reg,  pulse_cnt_next;
   logic [GAP_CNT_W-1:0]    gap_cnt_reg,    gap_cnt_next;
   logic [STROBE_CNT_W-1:0] strobe_cnt_reg, strobe_cnt_next;
   logic                    armed_reg,      armed_next;
   logic                    dig_pulse_reg,  dig_pulse_next;
   logic                    strobe_reg,     strobe_next;
   // counters run down or saturate; a running strobe always finishes
   always_comb begin
      pulse_cnt_next = (pulse_cnt_reg != '0) ? pulse_cnt_reg - 1'b1 : '0;
      gap_cnt_next = (gap_cnt_reg == GAP_MAX) ? GAP_MAX : gap_cnt_reg + 1'b1;
      strobe_cnt_next = (strobe_cnt_reg != '0) ? strobe_cnt_reg - 1'b1 : '0;
      armed_next      = armed_reg;
      // a new transition restarts the pulse rather than stretching it
      if (trans_evt) begin
         pulse_cnt_next = PULSE_CNT_W'(PULSE_CYC);
         gap_cnt_next   = '0;
         armed_next     = 1'b1;
      end else if (armed_reg && gap_cnt_next == GAP_MAX) begin
         armed_next      = 1'b0;
         strobe_cnt_next = STROBE_CNT_W'(STROBE_CYC);
      end
      dig_pulse_next = (pulse_cnt_next != '0);
      strobe_next    = (strobe_cnt_next != '0);
   end
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pulse_cnt_reg  <= '0;
         gap_cnt_reg    <= '0;
         strobe_cnt_reg <= '0;
         armed_reg      <= 1'b1;
         dig_pulse_reg  <= 1'b0;
         strobe_reg     <= 1'b0;
      end else begin
         pulse_cnt_reg  <= pulse_cnt_next;
         gap_cnt_reg    <= gap_cnt_next;
         strobe_cnt_reg <= strobe_cnt_next;
         armed_reg      <= armed_next;
         dig_pulse_reg  <= dig_pulse_next;
         strobe_reg     <= strobe_next;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // dividers, oscillator reset and phase detector
   logic                 dbl_reg,   dbl_next;
   logic                 bit_reg,   bit_next;
   logic                 up_reg,    up_next;
   logic                 dn_reg,    dn_next;
   logic [OSC_CNT_W-1:0] osc_cnt_reg, osc_cnt_next;
   logic                 su_reg,    su_next;
   logic                 sd_reg,    sd_next;
   logic                 isu_reg,   isu_next;
   logic                 isd_reg,   isd_next;
   logic                 ors_reg,   ors_next;
   logic                 ref_evt;
   logic                 fb_evt;
   always_comb begin
      dbl_next     = dbl_reg;
      bit_next     = bit_reg;
      osc_cnt_next = (osc_cnt_reg != '0) ? osc_cnt_reg - 1'b1 : osc_cnt_reg;
      // flip-flop halving chain: 4F to 2F to 1F
      if (osc_rise) begin
         dbl_next = ~dbl_reg;
         if (!dbl_reg)
            bit_next = ~bit_reg;
      end
      // reference and feedback follow the read gate
      ref_evt = gate_s ? trans_evt : master_rise;
      fb_evt  = gate_s ? (osc_rise & ~dbl_reg)
                       : (osc_rise & ~dbl_reg & ~bit_reg);
      up_next = up_reg | ref_evt;
      dn_next = dn_reg | fb_evt;
      // both registered: the comparison is done, clear for the next one
      if (up_reg && dn_reg) begin
         up_next = ref_evt;
         dn_next = fb_evt;
      end
      // entering read mode restarts the loop from a known phase
      if (gate_rise) begin
         up_next      = 1'b0;
         dn_next      = 1'b0;
         dbl_next     = 1'b0;
         bit_next     = 1'b0;
         osc_cnt_next = OSC_CNT_W'(OSC_RESET_CYC);
      end
      if (gate_fall) begin
         up_next = 1'b0;
         dn_next = 1'b0;
      end
      su_next  = gate_s & up_next;
      sd_next  = gate_s & dn_next;
      isu_next = ~gate_s & up_next;
      isd_next = ~gate_s & dn_next;
      ors_next = (osc_cnt_next != '0);
   end
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         dbl_reg     <= 1'b0;
         bit_reg     <= 1'b0;
         up_reg      <= 1'b0;
         dn_reg      <= 1'b0;
         osc_cnt_reg <= '0;
         su_reg      <= 1'b0;
         sd_reg      <= 1'b0;
         isu_reg     <= 1'b0;
         isd_reg     <= 1'b0;
         ors_reg     <= 1'b0;
      end else begin
         dbl_reg     <= dbl_next;
         bit_reg     <= bit_next;
         up_reg      <= up_next;
         dn_reg      <= dn_next;
         osc_cnt_reg <= osc_cnt_next;
         su_reg      <= su_next;
         sd_reg      <= sd_next;
         isu_reg     <= isu_next;
         isd_reg     <= isd_next;
         ors_reg     <= ors_next;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // MFM to NRZ: a pulse in the centre half cell is a one
   logic win_reg,  win_next;
   logic nrz_reg,  nrz_next;
   logic rclk_reg, rclk_next;
   logic bit_rise;
   always_comb begin
      bit_rise  = bit_next & ~bit_reg;
      win_next  = win_reg;
      nrz_next  = nrz_reg;
      if (bit_rise) begin
         nrz_next = gate_s & win_reg;
         win_next = 1'b0;
      end
      // a pulse while the double rate clock is high is kept for the next cell
      if (gate_s && trans_evt && dbl_reg)
         win_next = 1'b1;
      if (!gate_s)
         nrz_next = 1'b0;
      rclk_next = gate_s & bit_next;
   end
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         win_reg  <= 1'b0;
         nrz_reg  <= 1'b0;
         rclk_reg <= 1'b0;
      end else begin
         win_reg  <= win_next;
         nrz_reg  <= nrz_next;
         rclk_reg <= rclk_next;
      end
   end
   // every output straight from a flip-flop
   assign digitized_read_pulse   = dig_pulse_reg;
   assign boundary_strobe        = strobe_reg;
   assign speed_up_request       = su_reg;
   assign slow_down_request      = sd_reg;
   assign idle_speed_up_request  = isu_reg;
   assign idle_slow_down_request = isd_reg;
   assign oscillator_reset_pulse = ors_reg;
   assign double_rate_clock      = dbl_reg;
   assign bit_rate_clock         = bit_reg;
   assign read_clock             = rclk_reg;
   assign nrz_read_data          = nrz_reg;
   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // strobe length counter, read only by the checks
   logic [STROBE_CNT_W:0] strobe_len_reg;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         strobe_len_reg <= '0;
      else
         strobe_len_reg <= strobe_reg ? strobe_len_reg + 1'b1 : '0;
   end
   a_pulse_fixed_width: assert property (
      trans_evt |=> digitized_read_pulse [*2])
      else $error("read pulse not formed");
   a_pulse_ends: assert property (
      trans_evt ##1 !trans_evt [*2] |=> !digitized_read_pulse)
      else $error("read pulse too long");
   a_strobe_after_gap: assert property (
      $rose(boundary_strobe) |-> gap_cnt_reg == GAP_MAX && !armed_reg)
      else $error("boundary strobe without gap");
   a_strobe_length: assert property (
      $fell(boundary_strobe) |-> strobe_len_reg == STROBE_CYC)
      else $error("boundary strobe length wrong");
   a_rearm_on_pulse: assert property (
      trans_evt |=> armed_reg && gap_cnt_reg == '0)
      else $error("detector not re-armed");
   a_gate_blocks_req: assert property (
      !$past(gate_s) |-> !speed_up_request && !slow_down_request &&
                         !read_clock && !nrz_read_data)
      else $error("read path active without gate");
   a_speed_up_first: assert property (
      gate_s && !gate_rise && trans_evt && !up_reg && !dn_reg && !fb_evt
      |=> speed_up_request && !slow_down_request)
      else $error("speed-up not raised");
   a_slow_down_first: assert property (
      gate_s && !gate_rise && fb_evt && !up_reg && !dn_reg && !trans_evt
      |=> slow_down_request && !speed_up_request)
      else $error("slow-down not raised");
   a_mutual_clear: assert property (
      up_reg && dn_reg && !ref_evt && !fb_evt && !gate_rise
      |=> !up_reg && !dn_reg)
      else $error("requests not cleared");
   a_osc_reset: assert property (
      gate_rise |=> oscillator_reset_pulse [*2] ##1 !oscillator_reset_pulse)
      else $error("oscillator reset pulse wrong");
   a_divider: assert property (
      osc_rise && !gate_rise |=> double_rate_clock != $past(double_rate_clock))
      else $error("double rate not toggled");
   a_idle_lock: assert property (
      !gate_s && master_rise && !up_reg && !dn_reg && !fb_evt && !gate_fall
      |=> idle_speed_up_request)
      else $error("idle lock request missing");
   c_boundary: cover property ($rose(boundary_strobe));
   c_speed_up: cover property ($rose(speed_up_request));
   c_slow_down: cover property ($rose(slow_down_request));
   c_nrz_one: cover property ($rose(nrz_read_data));
endmodule

// >>> tb/controller_model.sv
// behavioural controller board: read gate, master clock, strobe and data intake
module controller_model (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic nrst,
   // controller outputs
   output logic      read_gate_enable,
   output logic      master_bit_clock,
   // device results
   input  wire logic boundary_strobe,
   input  wire logic read_clock,
   input  wire logic nrz_read_data
);
   timeunit 1ns;
   timeprecision 1ps;
   int         n_strobe;
   logic [7:0] nrz_shift_reg;
   logic       clk_d_reg;
   logic       stb_d_reg;

   // gate stays idle unless a read is under way
   initial begin
      read_gate_enable = 1'b0;
      master_bit_clock = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // read gate control
   task start_read();
      @(posedge sys_clk) #2 read_gate_enable = 1'b1;
   endtask
   task end_read();
      @(posedge sys_clk) #2 read_gate_enable = 1'b0;
   endtask
   // one master clock cycle; clock stands still afterwards
   task master_tick();
      @(posedge sys_clk) #2 master_bit_clock = 1'b1;
      repeat (4) @(posedge sys_clk);
      #2 master_bit_clock = 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // count strobes, take data on read clock rise only in read mode
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         n_strobe      <= 0;
         nrz_shift_reg <= 8'h00;
         clk_d_reg     <= 1'b0;
         stb_d_reg     <= 1'b0;
      end else begin
         clk_d_reg <= read_clock;
         stb_d_reg <= boundary_strobe;
         if (boundary_strobe && !stb_d_reg) begin
            n_strobe <= n_strobe + 1;
         end
         // writing saturates the read path, so only read mode counts
         if (read_gate_enable && read_clock && !clk_d_reg) begin
            nrz_shift_reg <= {nrz_shift_reg[6:0], nrz_read_data};
         end
      end
   end
endmodule

// >>> tb/tb.sv
// self-checking bench for the read pulse and sync logic
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import read_chan_pkg::*;
   // short gap keeps the run brief
   localparam int GAP   = 200;
   localparam int LIMIT = 5000;
   logic sys_clk                    = 1'b0;
   logic nrst                       = 1'b0;
   logic read_transition            = 1'b0;
   logic quad_rate_oscillator_clock = 1'b0;
   logic read_gate_enable, master_bit_clock;
   logic digitized_read_pulse, boundary_strobe, oscillator_reset_pulse;
   logic speed_up_request, slow_down_request;
   logic idle_speed_up_request, idle_slow_down_request;
   logic double_rate_clock, bit_rate_clock, read_clock, nrz_read_data;
   int   miscompares = 0;
   int   n_compared  = 0;
   int   cycles      = 0;

   // 40 MHz clock
   always #12.5 sys_clk = ~sys_clk;

   disk_read_pulse_sync_logic #(.GAP_CYCLES(GAP)) dut (
      .sys_clk(sys_clk), .nrst(nrst),
      .read_transition(read_transition),
      .read_gate_enable(read_gate_enable),
      .master_bit_clock(master_bit_clock),
      .quad_rate_oscillator_clock(quad_rate_oscillator_clock),
      .digitized_read_pulse(digitized_read_pulse),
      .boundary_strobe(boundary_strobe),
      .speed_up_request(speed_up_request),
      .slow_down_request(slow_down_request),
      .idle_speed_up_request(idle_speed_up_request),
      .idle_slow_down_request(idle_slow_down_request),
      .oscillator_reset_pulse(oscillator_reset_pulse),
      .double_rate_clock(double_rate_clock),
      .bit_rate_clock(bit_rate_clock),
      .read_clock(read_clock), .nrz_read_data(nrz_read_data));

   controller_model ctl (
      .sys_clk(sys_clk), .nrst(nrst),
      .read_gate_enable(read_gate_enable),
      .master_bit_clock(master_bit_clock),
      .boundary_strobe(boundary_strobe),
      .read_clock(read_clock), .nrz_read_data(nrz_read_data));

   ////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic sig(input int s);
      case (s)
         0:       return digitized_read_pulse;
         1:       return boundary_strobe;
         default: return oscillator_reset_pulse;
      endcase
   endfunction
   task expect_bit(input logic got, input logic exp, input string msg);
      n_compared++;
      if (got !== exp) begin
         $display("wrong value at %0t: %s", $time, msg);
         miscompares++;
      end
   endtask
   task expect_n(input int got, input int lo, input int hi, input string msg);
      n_compared++;
      if (got < lo || got > hi) begin
         $display("wrong value at %0t: %s %0d", $time, msg, got);
         miscompares++;
      end
   endtask
   // waits for a rise, then measures the high time
   task high_len(input int s, output int t, output int w);
      t = 0;
      w = 0;
      while (sig(s) !== 1'b1 && t < 600) begin
         @(negedge sys_clk);
         t++;
      end
      while (sig(s) === 1'b1 && w < 200) begin
         @(negedge sys_clk);
         w++;
      end
   endtask
   task settle(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task flip();
      @(posedge sys_clk) #2 read_transition = ~read_transition;
   endtask
   // slow oscillator edge so the sampled copy sees it
   task osc_rise();
      @(posedge sys_clk) #2 quad_rate_oscillator_clock = 1'b1;
      repeat (4) @(posedge sys_clk);
      #2 quad_rate_oscillator_clock = 1'b0;
      settle(4);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // scenarios
   task t_pulse();
      int t, w;
      // rising and falling edges both count
      for (int i = 0; i < 2; i++) begin
         flip();
         high_len(0, t, w);
         expect_n(w, PULSE_CYC, PULSE_CYC, "pulse width");
      end
   endtask
   task t_boundary();
      int t, w, hits;
      flip();
      high_len(1, t, w);
      expect_n(t, GAP, GAP + 10, "gap before strobe");
      expect_n(w, STROBE_CYC, STROBE_CYC, "strobe width");
      hits = 0;
      // no second strobe without a pulse; pulses every 100 keep it off
      for (int i = 0; i < 7; i++) begin
         if (i > 2) flip();
         for (int k = 0; k < 100; k++) begin
            @(negedge sys_clk);
            if (boundary_strobe === 1'b1) hits++;
         end
      end
      expect_n(hits, 0, 0, "strobe while quiet or busy");
      flip();
      high_len(1, t, w);
      expect_n(t, GAP, GAP + 10, "re-armed gap");
      expect_n(ctl.n_strobe, 2, 2, "strobe count");
   endtask
   task t_read_lock();
      int t, w;
      ctl.start_read();
      high_len(2, t, w);
      expect_n(w, OSC_RESET_CYC, OSC_RESET_CYC, "osc reset");
      settle(4);
      flip();
      settle(6);
      expect_bit(speed_up_request, 1'b1, "speed-up");
      expect_bit(slow_down_request, 1'b0, "slow with speed");
      expect_bit(idle_speed_up_request, 1'b0, "idle path in read");
      osc_rise();
      expect_bit(speed_up_request, 1'b0, "speed-up clear");
      expect_bit(double_rate_clock, 1'b1, "double rate");
      expect_bit(bit_rate_clock, 1'b1, "bit rate");
      osc_rise();
      osc_rise();
      expect_bit(slow_down_request, 1'b1, "slow-down");
      expect_bit(speed_up_request, 1'b0, "speed with slow");
      expect_bit(bit_rate_clock, 1'b0, "bit rate halves");
      expect_bit(read_clock, 1'b0, "read clock low");
      flip();
      settle(6);
      expect_bit(slow_down_request, 1'b0, "slow-down clear");
      osc_rise();
      osc_rise();
      expect_bit(nrz_read_data, 1'b1, "decoded one");
      expect_bit(read_clock, 1'b1, "read clock high");
      // controller took a zero, then the decoded one
      expect_bit(ctl.nrz_shift_reg == 8'h01, 1'b1, "bits taken");
   endtask
   task t_idle_lock();
      ctl.end_read();
      settle(6);
      expect_bit(speed_up_request | slow_down_request, 1'b0, "idle req");
      expect_bit(read_clock | nrz_read_data, 1'b0, "read gated");
      ctl.master_tick();
      settle(2);
      expect_bit(idle_speed_up_request, 1'b1, "lock to master");
      expect_bit(speed_up_request, 1'b0, "read req idle");
      for (int i = 0; i < 4 && idle_speed_up_request === 1'b1; i++) begin
         osc_rise();
      end
      expect_bit(idle_speed_up_request, 1'b0, "idle clear");
      // oscillator first in idle: slow side raised until master arrives
      repeat (4) osc_rise();
      expect_bit(idle_slow_down_request, 1'b1, "idle slow-down");
      expect_bit(idle_speed_up_request, 1'b0, "idle both");
      ctl.master_tick();
      settle(2);
      expect_bit(idle_slow_down_request, 1'b0, "idle slow clear");
   endtask

   ////////////////////////////////////////////////////////////////////////
   // verdict and run control
   task tally_and_finish();
      $display("compared %0d, wrong %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // hang guard
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         miscompares++;
         tally_and_finish();
      end
   end
   // main sequence
   initial begin
      repeat (4) @(posedge sys_clk);
      #2 nrst = 1'b1;
      t_pulse();
      t_boundary();
      t_read_lock();
      t_idle_lock();
      tally_and_finish();
   end
endmodule
